/* File: core/dds_pkg.sv */
package dds_pkg;
   // serial register addresses
   localparam logic [4:0] ADDR_CTRL_ONE = 5'h00;
   localparam logic [4:0] ADDR_CTRL_TWO = 5'h01;
   localparam logic [4:0] ADDR_AMP_SCALE = 5'h02;
   localparam logic [4:0] ADDR_RAMP_RATE = 5'h03;
   localparam logic [4:0] ADDR_FREQ_STEP = 5'h04;
   localparam logic [4:0] ADDR_PHASE_SHIFT = 5'h05;

   // register lengths in bits
   localparam logic [5:0] BITS_CTRL_ONE = 6'h20;
   localparam logic [5:0] BITS_CTRL_TWO = 6'h18;
   localparam logic [5:0] BITS_AMP_SCALE = 6'h10;
   localparam logic [5:0] BITS_RAMP_RATE = 6'h08;
   localparam logic [5:0] BITS_FREQ_STEP = 6'h20;
   localparam logic [5:0] BITS_PHASE_SHIFT = 6'h10;
   localparam logic [5:0] BITS_UNMAPPED = 6'h08;
   localparam logic [5:0] BITS_WORD = 6'h20;

   // instruction byte layout
   localparam int INSTR_READ_BIT = 7;
   localparam logic [3:0] INSTR_LAST_BIT = 4'h7;

   // control word one fields
   localparam int C1_CLEAR_AUTO_BIT = 13;
   localparam int C1_CLEAR_NOW_BIT = 8;
   localparam int C1_COMP_DOWN_BIT = 6;
   localparam int C1_CLOCK_STOP_BIT = 4;
   // control word two fields
   localparam int C2_XTAL_OUT_BIT = 9;
   localparam int C2_MULT_HI = 7;
   localparam int C2_MULT_LO = 3;

   // reset values
   localparam logic [31:0] CTRL_ONE_ACTIVE_RST = 32'h0000_0100;
   localparam logic [31:0] CTRL_ONE_BUF_RST = 32'h0000_0000;
   localparam logic [23:0] CTRL_TWO_RST = 24'h00_0000;
   localparam logic [31:0] FREQ_STEP_RST = 32'h0000_0000;
   localparam logic [15:0] PHASE_SHIFT_RST = 16'h0000;

   // pll multiplier range
   localparam logic [4:0] MULT_MIN = 5'h04;
   localparam logic [4:0] MULT_MAX = 5'h14;
   localparam logic [4:0] MULT_BYPASS = 5'h01;

   // phase datapath
   localparam int ACC_BITS = 32;
   localparam int PHASE_BITS = 14;
   localparam int DAC_BITS = 14;
   localparam logic [13:0] QUARTER_TURN = 14'h1000;
   localparam logic [13:0] DAC_MID = 14'h2000;
   localparam logic [12:0] AMP_MAX = 13'h1FFF;

   // timing
   localparam int CLK_HZ = 50_000_000;
   localparam int PLL_LOCK_US = 1000;
   localparam int PLL_LOCK_CYCLES_DEF = (CLK_HZ / 1_000_000) * PLL_LOCK_US;

   typedef enum logic [1:0] {
      SP_INSTR = 2'b00,
      SP_WRITE = 2'b01,
      SP_READ = 2'b11,
      SP_DONE = 2'b10
   } dds_port_state_t;

   typedef enum logic [2:0] {
      CM_OSC_PLL = 3'h0,
      CM_OSC_DIRECT = 3'h1,
      CM_EXT_PLL = 3'h3,
      CM_EXT_DIRECT = 3'h2,
      CM_STOP_OSC = 3'h6,
      CM_STOP_EXT = 3'h7
   } dds_clock_mode_t;

   function automatic logic [5:0] ddsRegBits(input logic [4:0] a);
      case (a)
         ADDR_CTRL_ONE: ddsRegBits = BITS_CTRL_ONE;
         ADDR_CTRL_TWO: ddsRegBits = BITS_CTRL_TWO;
         ADDR_AMP_SCALE: ddsRegBits = BITS_AMP_SCALE;
         ADDR_RAMP_RATE: ddsRegBits = BITS_RAMP_RATE;
         ADDR_FREQ_STEP: ddsRegBits = BITS_FREQ_STEP;
         ADDR_PHASE_SHIFT: ddsRegBits = BITS_PHASE_SHIFT;
         default: ddsRegBits = BITS_UNMAPPED;
      endcase
   endfunction : ddsRegBits
endpackage : dds_pkg

/* File: core/dds_cos_lut.sv */
module dds_cos_lut import dds_pkg::*; (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [PHASE_BITS-1:0] phase,
   output logic [DAC_BITS-1:0] amplitude
);
   // parabolic cosine: cheap, no table rom, a few percent shape error
   logic [13:0] sinPhase;
   logic halfNeg;
   logic [12:0] halfPos;
   logic [13:0] halfRest;
   logic [26:0] prod;
   logic [12:0] mag;
   logic [DAC_BITS-1:0] amp_d;
   logic [DAC_BITS-1:0] amp_q;

   assign sinPhase = phase + QUARTER_TURN;
   assign halfNeg = sinPhase[13];
   assign halfPos = sinPhase[12:0];
   assign halfRest = 14'h2000 - {1'b0, halfPos};
   assign prod = {14'h0000, halfPos} * {13'h0000, halfRest};
   // peak product is exactly 2^24, which needs clipping to 13 bits
   assign mag = prod[24] ? AMP_MAX : prod[23:11];
   assign amp_d = halfNeg ? (DAC_MID - {1'b0, mag}) : (DAC_MID + {1'b0, mag});

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         amp_q <= DAC_MID;
      end else begin
         amp_q <= amp_d;
      end
   end

   assign amplitude = amp_q;
endmodule : dds_cos_lut

/* File: core/dds_core_top.sv */
// Summary of operation
// - phase accumulator is 32 bits, output frequency is step times rate over 2^32
// - steps above 2^31 alias to rate minus nominal via natural wraparound
// - 14-bit phase shift word adds 360*word/2^14 degrees to phase
// - zero step freezes phase; zero shift keeps running; neither forces zero
// - control word one bits 13 and 8 force accumulator output to zero
// - after reset active clear bit reads one, buffered copy zero, until commit
// - pll multiplier is bits 7..3 of control word two
// - multiplier 4 through 20 multiplies reference clock by that integer
// - multiplier outside 4..20 bypasses and shuts down the pll
// - oscillator select high runs crystal oscillator; low disables it and buffer
// - control word one bit 4 stops system clock, oscillator keeps running
// - control word two bit 9 enables buffered oscillator output pin
// - six clock modes from select pin, stop bit, multiplier; stop gives no clock
// - control word one bit 6 powers down the comparator
// - phase converts through cosine into a 14-bit dac code
// - serial port reads and writes control words, frequency step and phase shift, msb or lsb first; other addresses read zero
// - serial port runs two-wire shared data pin or three-wire split pins
// - abort pin high ends any transfer at once; restart after it falls
module dds_core_top import dds_pkg::*; #(
   parameter int unsigned PLL_LOCK_CYCLES = PLL_LOCK_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic serialClock,
   input wire logic portSelectN,
   input wire logic portAbortPin,
   input wire logic sdioIn,
   output logic sdioOut,
   output logic sdioOe,
   output logic serialDataOutPin,
   input wire logic commitUpdate,
   input wire logic lsbFirstSel,
   input wire logic threeWireSel,
   input wire logic oscillatorSelectPin,
   output logic [DAC_BITS-1:0] dacCode,
   output logic oscillatorEnable,
   output logic crystalOutEnable,
   output logic clockInputEnable,
   output logic pllEnable,
   output logic [4:0] pllMultiplier,
   output logic pllLocked,
   output logic systemClockRun,
   output dds_clock_mode_t clockMode,
   output logic comparatorPowerDown
);
   // serial port state
   dds_port_state_t state_q;
   logic sclkPrev_q;
   logic [5:0] bitCnt_q;
   logic [31:0] inShift_q;
   logic [31:0] outShift_q;
   logic [4:0] addr_q;

   // buffered and active register copies
   logic [31:0] ctrlOneBuf_q;
   logic [31:0] ctrlOneAct_q;
   logic [23:0] ctrlTwoBuf_q;
   logic [23:0] ctrlTwoAct_q;
   logic [31:0] freqStepBuf_q;
   logic [31:0] freqStepAct_q;
   logic [15:0] phaseShiftBuf_q;
   logic [15:0] phaseShiftAct_q;

   // datapath and pll lock timer
   logic [ACC_BITS-1:0] acc_q;
   logic [4:0] multPrev_q;
   logic [31:0] lockCnt_q;

   // serial decode
   logic sclkRise;
   logic sclkFall;
   logic portIdle;
   logic [31:0] shiftedIn;
   logic [7:0] instrByte;
   logic [4:0] selAddr;
   logic [5:0] selBits;
   logic [5:0] shiftPad;
   logic [31:0] bitMask;
   logic [31:0] writeValue;
   logic [31:0] readValue;
   logic [31:0] readAligned;
   logic outBit;
   logic instrDone;
   logic dataDone;
   logic regWrite;

   assign sclkRise = serialClock & ~sclkPrev_q;
   assign sclkFall = ~serialClock & sclkPrev_q;
   // select pin is optional: tie low and the abort pin alone frames transfers
   assign portIdle = portAbortPin | portSelectN;
   // the same shifter takes instruction and data in either bit order
   assign shiftedIn = lsbFirstSel ? {sdioIn, inShift_q[31:1]} : {inShift_q[30:0], sdioIn};
   assign instrByte = lsbFirstSel ? shiftedIn[31:24] : shiftedIn[7:0];
   assign instrDone = (state_q == SP_INSTR) && (bitCnt_q[3:0] == INSTR_LAST_BIT);
   assign selAddr = (state_q == SP_INSTR) ? instrByte[4:0] : addr_q;
   assign selBits = ddsRegBits(selAddr);
   assign shiftPad = BITS_WORD - selBits;
   assign bitMask = (selBits == BITS_WORD) ? 32'hFFFF_FFFF
                  : ((32'h0000_0001 << selBits) - 32'h0000_0001);
   assign writeValue = lsbFirstSel ? (shiftedIn >> shiftPad) : (shiftedIn & bitMask);
   assign dataDone = (bitCnt_q == (selBits - 6'h01));
   assign regWrite = ~portIdle & sclkRise & (state_q == SP_WRITE) & dataDone;

   // reads show the live copy, so the power-up clear bit reads back as set
   always_comb begin
      case (selAddr)
         ADDR_CTRL_ONE: readValue = ctrlOneAct_q;
         ADDR_CTRL_TWO: readValue = {8'h00, ctrlTwoAct_q};
         ADDR_FREQ_STEP: readValue = freqStepAct_q;
         ADDR_PHASE_SHIFT: readValue = {16'h0000, phaseShiftAct_q};
         default: readValue = 32'h0000_0000;
      endcase
   end

   assign readAligned = lsbFirstSel ? readValue : (readValue << shiftPad);
   assign outBit = lsbFirstSel ? outShift_q[0] : outShift_q[31];

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sclkPrev_q <= 1'b0;
      end else begin
         sclkPrev_q <= serialClock;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= SP_INSTR;
         bitCnt_q <= 6'h00;
         inShift_q <= 32'h0000_0000;
         addr_q <= 5'h00;
      end else if (portIdle) begin
         state_q <= SP_INSTR;
         bitCnt_q <= 6'h00;
      end else if (sclkRise) begin
         inShift_q <= shiftedIn;
         bitCnt_q <= bitCnt_q + 6'h01;
         case (state_q)
            SP_INSTR: begin
               if (instrDone) begin
                  addr_q <= instrByte[4:0];
                  bitCnt_q <= 6'h00;
                  state_q <= instrByte[INSTR_READ_BIT] ? SP_READ : SP_WRITE;
               end
            end
            SP_WRITE: begin
               if (dataDone) begin
                  state_q <= SP_DONE;
               end
            end
            SP_READ: begin
               if (dataDone) begin
                  state_q <= SP_DONE;
               end
            end
            SP_DONE: begin
               bitCnt_q <= bitCnt_q;
            end
            default: begin
               state_q <= SP_INSTR;
            end
         endcase
      end
   end

   // first read bit is presented at load; later bits move on falling edges
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         outShift_q <= 32'h0000_0000;
      end else if (~portIdle & sclkRise & instrDone) begin
         outShift_q <= readAligned;
      end else if (sclkFall & (state_q == SP_READ) & (bitCnt_q != 6'h00)) begin
         outShift_q <= lsbFirstSel ? (outShift_q >> 1) : (outShift_q << 1);
      end
   end

   // two-wire mode turns the shared pin around only during read data
   assign sdioOe = ~portIdle & (state_q == SP_READ) & ~threeWireSel;
   assign sdioOut = outBit;
   assign serialDataOutPin = threeWireSel & (state_q == SP_READ) & outBit;

   // buffer registers, loaded at the last bit of a write
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrlOneBuf_q <= CTRL_ONE_BUF_RST;
         ctrlTwoBuf_q <= CTRL_TWO_RST;
         freqStepBuf_q <= FREQ_STEP_RST;
         phaseShiftBuf_q <= PHASE_SHIFT_RST;
      end else if (regWrite) begin
         case (addr_q)
            ADDR_CTRL_ONE: ctrlOneBuf_q <= writeValue;
            ADDR_CTRL_TWO: ctrlTwoBuf_q <= writeValue[23:0];
            ADDR_FREQ_STEP: freqStepBuf_q <= writeValue;
            ADDR_PHASE_SHIFT: phaseShiftBuf_q <= writeValue[15:0];
            default: ctrlOneBuf_q <= ctrlOneBuf_q;
         endcase
      end
   end

   // active copies change only on commit
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrlOneAct_q <= CTRL_ONE_ACTIVE_RST;
         ctrlTwoAct_q <= CTRL_TWO_RST;
         freqStepAct_q <= FREQ_STEP_RST;
         phaseShiftAct_q <= PHASE_SHIFT_RST;
      end else if (commitUpdate) begin
         ctrlOneAct_q <= ctrlOneBuf_q;
         ctrlTwoAct_q <= ctrlTwoBuf_q;
         freqStepAct_q <= freqStepBuf_q;
         phaseShiftAct_q <= phaseShiftBuf_q;
      end
   end

   // clock generation controls
   logic [4:0] multField;
   logic multInRange;
   logic stopBit;

   assign multField = ctrlTwoAct_q[C2_MULT_HI:C2_MULT_LO];
   assign multInRange = (multField >= MULT_MIN) && (multField <= MULT_MAX);
   assign stopBit = ctrlOneAct_q[C1_CLOCK_STOP_BIT];
   assign pllEnable = multInRange;
   assign pllMultiplier = multInRange ? multField : MULT_BYPASS;
   assign oscillatorEnable = oscillatorSelectPin;
   assign crystalOutEnable = oscillatorSelectPin & ctrlTwoAct_q[C2_XTAL_OUT_BIT];
   assign clockInputEnable = ~stopBit;
   assign systemClockRun = ~stopBit;
   assign comparatorPowerDown = ctrlOneAct_q[C1_COMP_DOWN_BIT];

   // multiplier path is decided without regard to the stop bit
   always_comb begin
      case ({stopBit, oscillatorSelectPin, multInRange})
         3'b011: clockMode = CM_OSC_PLL;
         3'b010: clockMode = CM_OSC_DIRECT;
         3'b001: clockMode = CM_EXT_PLL;
         3'b000: clockMode = CM_EXT_DIRECT;
         3'b110: clockMode = CM_STOP_OSC;
         3'b111: clockMode = CM_STOP_OSC;
         default: clockMode = CM_STOP_EXT;
      endcase
   end

   // lock timer so the host can see the settling window it must wait out
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         multPrev_q <= CTRL_TWO_RST[C2_MULT_HI:C2_MULT_LO];
         lockCnt_q <= 32'h0000_0000;
      end else begin
         multPrev_q <= multField;
         if (multField != multPrev_q) begin
            lockCnt_q <= PLL_LOCK_CYCLES;
         end else if (lockCnt_q != 32'h0000_0000) begin
            lockCnt_q <= lockCnt_q - 32'h0000_0001;
         end
      end
   end

   assign pllLocked = ~multInRange | (lockCnt_q == 32'h0000_0000);

   // phase datapath
   logic clearAcc;
   logic [ACC_BITS-1:0] accOut;
   logic [PHASE_BITS-1:0] phaseAddr;

   assign clearAcc = ctrlOneAct_q[C1_CLEAR_AUTO_BIT] | ctrlOneAct_q[C1_CLEAR_NOW_BIT];
   assign accOut = clearAcc ? {ACC_BITS{1'b0}} : acc_q;

   // stopped system clock is modelled as a frozen accumulator
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         acc_q <= 32'h0000_0000;
      end else if (clearAcc) begin
         acc_q <= 32'h0000_0000;
      end else if (~stopBit) begin
         acc_q <= acc_q + freqStepAct_q;
      end
   end

   // shift word adds after the accumulator, so zero shift just passes phase
   assign phaseAddr = accOut[ACC_BITS-1:ACC_BITS-PHASE_BITS]
                    + phaseShiftAct_q[PHASE_BITS-1:0];

   dds_cos_lut cosLut (
      .clk(clk),
      .sys_rst(sys_rst),
      .phase(phaseAddr),
      .amplitude(dacCode)
   );
endmodule : dds_core_top

/* File: bench/dds_core_props.sv */
module dds_core_props import dds_pkg::*; #(
   parameter int unsigned PLL_LOCK_CYCLES = PLL_LOCK_CYCLES_DEF
) (
   input logic clk,
   input logic sys_rst,
   input logic portSelectN,
   input logic portAbortPin,
   input logic threeWireSel,
   input logic oscillatorSelectPin,
   input logic commitUpdate,
   input logic sdioOe,
   input logic serialDataOutPin,
   input logic [DAC_BITS-1:0] dacCode,
   input logic oscillatorEnable,
   input logic crystalOutEnable,
   input logic clockInputEnable,
   input logic pllEnable,
   input logic [4:0] pllMultiplier,
   input logic pllLocked,
   input logic systemClockRun,
   input dds_clock_mode_t clockMode
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // counts unlocked cycles, the lock wait is too long to unroll
   int unsigned lockCount_q;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) lockCount_q <= 0;
      else if (pllLocked) lockCount_q <= 0;
      else lockCount_q <= lockCount_q + 1;
   end
   a_osc_follows_pin: assert property (oscillatorEnable == oscillatorSelectPin)
      else $error("oscillator enable differs from select pin");
   a_xtal_out_gate: assert property (crystalOutEnable |-> oscillatorSelectPin)
      else $error("crystal output enabled with oscillator off");
   a_stop_both: assert property (systemClockRun == clockInputEnable)
      else $error("clock run and input buffer disagree");
   a_stop_mode: assert property (!systemClockRun |-> clockMode inside {CM_STOP_OSC, CM_STOP_EXT})
      else $error("stopped clock in a running mode");
   a_pll_range: assert property (pllEnable == (pllMultiplier >= MULT_MIN && pllMultiplier <= MULT_MAX))
      else $error("pll enable does not match multiplier range");
   a_bypass_value: assert property (!pllEnable |-> pllMultiplier == MULT_BYPASS)
      else $error("bypassed pll multiplier not one");
   a_lock_drop: assert property ($changed(pllMultiplier) && pllEnable |=> !pllLocked)
      else $error("pll kept lock across multiplier change");
   a_lock_bound: assert property (lockCount_q <= PLL_LOCK_CYCLES)
      else $error("pll lock took too long");
   a_frozen_dac: assert property ((!systemClockRun && !commitUpdate) [*4] |-> $stable(dacCode))
      else $error("dac moved while system clock stopped");
   a_deselect_quiet: assert property (portSelectN |=> !sdioOe && !serialDataOutPin)
      else $error("read data driven while deselected");
   a_abort_quiet: assert property (portAbortPin |=> !sdioOe)
      else $error("shared pin driven during abort");
   a_three_wire: assert property (threeWireSel |-> !sdioOe)
      else $error("shared pin driven in three-wire mode");
endmodule : dds_core_props

bind dds_core_top dds_core_props #(.PLL_LOCK_CYCLES(PLL_LOCK_CYCLES)) props (.*);

/* File: bench/dds_host_model.sv */
module dds_host_model (
   input wire logic clk,
   input wire logic sdioOut,
   input wire logic sdioOe,
   input wire logic serialDataOutPin,
   input wire logic lsbFirstSel,
   input wire logic threeWireSel,
   output logic serialClock,
   output logic portSelectN,
   output logic portAbortPin,
   output logic sdioIn
);
   timeunit 1ns;
   timeprecision 1ps;
   logic hostBit;
   // shared pin: core wins while it drives, else host level
   assign sdioIn = sdioOe ? sdioOut : hostBit;
   initial begin
      serialClock = 1'b0;
      portSelectN = 1'b1;
      portAbortPin = 1'b0;
      hostBit = 1'b0;
   end
   // serial clock stays low outside frames; 8 clk per bit keeps it below clk/4
   task automatic xfer(input logic rd, input logic [4:0] addr, input logic [31:0] wd,
         input int n, input int abortAt, output logic [31:0] rdat);
      logic [7:0] ins;
      logic b;
      int k;
      ins = {rd, 2'b00, addr};
      rdat = '0;
      @(negedge clk);
      portSelectN = 1'b0;
      for (int i = 0; i < n + 8; i++) begin
         // keep clocking under abort so a port that ignores it would finish the write
         if (i == abortAt) portAbortPin = 1'b1;
         k = lsbFirstSel ? i - 8 : n + 7 - i;
         if (i < 8) b = lsbFirstSel ? ins[i] : ins[7 - i];
         else b = rd ? ~hostBit : wd[k];
         @(negedge clk);
         serialClock = 1'b0;
         hostBit = b;
         repeat (4) @(negedge clk);
         if (i >= 8) rdat[k] = threeWireSel ? serialDataOutPin : sdioIn;
         serialClock = 1'b1;
         repeat (3) @(negedge clk);
      end
      @(negedge clk);
      serialClock = 1'b0;
      repeat (3) @(negedge clk);
      portSelectN = 1'b1;
      portAbortPin = 1'b0;
      repeat (4) @(negedge clk);
   endtask : xfer
endmodule : dds_host_model

/* File: bench/dds_core_clock_config_test.sv */
module dds_core_clock_config_test import dds_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, sys_rst, serialClock, portSelectN, portAbortPin, sdioIn, sdioOut, sdioOe;
   logic serialDataOutPin, commitUpdate, lsbFirstSel, threeWireSel, oscillatorSelectPin;
   logic oscillatorEnable, crystalOutEnable, clockInputEnable, pllEnable, pllLocked;
   logic systemClockRun, comparatorPowerDown, inr;
   logic [DAC_BITS-1:0] dacCode;
   logic [4:0] pllMultiplier;
   dds_clock_mode_t clockMode;
   int nErrors = 0;
   int samplesChecked = 0;
   logic [31:0] rv;
   logic [DAC_BITS-1:0] s [0:7];
   // multipliers at both ends of the 4..20 range plus one step outside each end
   logic [4:0] mt [4] = '{5'h03, 5'h04, 5'h14, 5'h15};
   logic [31:0] st [2] = '{32'h4000_0000, 32'hC000_0000};

   dds_core_top #(.PLL_LOCK_CYCLES(20)) DUT (.clk(clk), .sys_rst(sys_rst),
      .serialClock(serialClock), .portSelectN(portSelectN), .portAbortPin(portAbortPin),
      .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOe(sdioOe), .serialDataOutPin(serialDataOutPin),
      .commitUpdate(commitUpdate), .lsbFirstSel(lsbFirstSel), .threeWireSel(threeWireSel),
      .oscillatorSelectPin(oscillatorSelectPin), .dacCode(dacCode),
      .oscillatorEnable(oscillatorEnable), .crystalOutEnable(crystalOutEnable),
      .clockInputEnable(clockInputEnable), .pllEnable(pllEnable),
      .pllMultiplier(pllMultiplier), .pllLocked(pllLocked), .systemClockRun(systemClockRun),
      .clockMode(clockMode), .comparatorPowerDown(comparatorPowerDown));
   dds_host_model host (.clk(clk), .sdioOut(sdioOut), .sdioOe(sdioOe),
      .serialDataOutPin(serialDataOutPin), .lsbFirstSel(lsbFirstSel),
      .threeWireSel(threeWireSel), .serialClock(serialClock), .portSelectN(portSelectN),
      .portAbortPin(portAbortPin), .sdioIn(sdioIn));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         nErrors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [4:0] a, input logic [31:0] d, input int n);
      logic [31:0] t;
      host.xfer(1'b0, a, d, n, -1, t);
   endtask : wr
   task automatic rd(input logic [4:0] a, input int n, output logic [31:0] d);
      host.xfer(1'b1, a, 32'h0, n, -1, d);
   endtask : rd
   task automatic commit();
      @(negedge clk);
      commitUpdate = 1'b1;
      @(negedge clk);
      commitUpdate = 1'b0;
      repeat (3) @(negedge clk);
   endtask : commit
   task automatic grab();
      for (int i = 0; i < 8; i++) begin
         @(negedge clk);
         s[i] = dacCode;
      end
   endtask : grab
   task automatic complete_run();
      if (nErrors == 0 && samplesChecked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : complete_run
   // generous span: the full sequence needs about 9000 cycles
   initial begin
      repeat (60000) @(posedge clk);
      nErrors++;
      complete_run();
   end
   initial begin
      sys_rst = 1'b1;
      commitUpdate = 1'b0;
      lsbFirstSel = 1'b0;
      threeWireSel = 1'b0;
      oscillatorSelectPin = 1'b1;
      repeat (5) @(negedge clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge clk);
      check("dac after reset", 32'(dacCode), 32'h3FFF);
      rd(ADDR_CTRL_ONE, 32, rv);
      check("ctrl one reset", rv, CTRL_ONE_ACTIVE_RST);
      check("mode reset", 32'(clockMode), 32'(CM_OSC_DIRECT));
      wr(ADDR_CTRL_ONE, 32'h0000_0100, 32);
      wr(ADDR_PHASE_SHIFT, 32'h0000_1000, 16);
      commit();
      check("quarter shift", 32'(dacCode), 32'(DAC_MID));
      wr(ADDR_PHASE_SHIFT, 32'h0, 16);
      wr(ADDR_FREQ_STEP, st[0], 32);
      wr(ADDR_CTRL_ONE, 32'h0000_2000, 32);
      commit();
      grab();
      check("held by auto clear", 32'(s[7]), 32'h3FFF);
      wr(ADDR_CTRL_ONE, 32'h0, 32);
      foreach (st[j]) begin
         wr(ADDR_FREQ_STEP, st[j], 32);
         commit();
         grab();
         for (int i = 0; i < 4; i++) check("period four", 32'(s[i]), 32'(s[i + 4]));
         check("zero crossings", 32'((s[0] == DAC_MID) + (s[1] == DAC_MID)
            + (s[2] == DAC_MID) + (s[3] == DAC_MID)), 32'h2);
      end
      wr(ADDR_FREQ_STEP, 32'h0, 32);
      grab();
      check("moving before commit", 32'(s[0] !== s[1]), 32'h1);
      commit();
      grab();
      check("zero step holds", 32'(s[0] === s[7]), 32'h1);
      // running step so the stop bit has something to freeze
      wr(ADDR_FREQ_STEP, st[0], 32);
      for (int p = 0; p < 2; p++) begin
         oscillatorSelectPin = p[0];
         foreach (mt[m]) begin
            wr(ADDR_CTRL_TWO, (32'(mt[m]) << 3) | 32'h200, 24);
            commit();
            repeat (25) @(negedge clk);
            inr = mt[m] >= 5'h04 && mt[m] <= 5'h14;
            check("pll enable", 32'(pllEnable), 32'(inr));
            check("multiplier", 32'(pllMultiplier), inr ? 32'(mt[m]) : 32'h1);
            check("locked", 32'(pllLocked), 32'h1);
            check("mode", 32'(clockMode), p ? (inr ? 32'(CM_OSC_PLL) : 32'(CM_OSC_DIRECT))
               : (inr ? 32'(CM_EXT_PLL) : 32'(CM_EXT_DIRECT)));
            check("osc", 32'(oscillatorEnable), 32'(p));
            check("xtal out", 32'(crystalOutEnable), 32'(p));
         end
         wr(ADDR_CTRL_ONE, 32'h0000_0050, 32);
         commit();
         check("clock run", 32'(systemClockRun), 32'h0);
         check("input buffer", 32'(clockInputEnable), 32'h0);
         check("osc kept", 32'(oscillatorEnable), 32'(p));
         check("comparator", 32'(comparatorPowerDown), 32'h1);
         check("stop mode", 32'(clockMode), p ? 32'(CM_STOP_OSC) : 32'(CM_STOP_EXT));
         grab();
         check("stop freezes dac", 32'(s[0] === s[7]), 32'h1);
         wr(ADDR_CTRL_ONE, 32'h0, 32);
         commit();
      end
      wr(ADDR_CTRL_TWO, 32'h0000_0060, 24);
      commit();
      check("xtal out off", 32'(crystalOutEnable), 32'h0);
      rd(ADDR_CTRL_TWO, 24, rv);
      check("ctrl two read", rv, 32'h0000_0060);
      lsbFirstSel = 1'b1;
      threeWireSel = 1'b1;
      wr(ADDR_FREQ_STEP, 32'h1234_5678, 32);
      commit();
      rd(ADDR_FREQ_STEP, 32, rv);
      check("lsb three wire read", rv, 32'h1234_5678);
      rd(5'h1F, 8, rv);
      check("unmapped read", rv, 32'h0);
      host.xfer(1'b0, ADDR_FREQ_STEP, 32'hFFFF_FFFF, 32, 20, rv);
      commit();
      rd(ADDR_FREQ_STEP, 32, rv);
      check("aborted write", rv, 32'h1234_5678);
      complete_run();
   end
endmodule : dds_core_clock_config_test
